// ===== dv/board_host_model.sv
`timescale 1ns/100ps
module board_host_model (
    // clock
    input wire logic clk_in,
    // board enables and host commands
    output logic [1:0] aux_en_out = 2'h0,
    output logic [1:0] main_en_out = 2'h0,
    output logic wr_out = 1'b0,
    output logic [1:0] host_aux_out = 2'h0,
    output logic [1:0] host_main_out = 2'h0,
    output logic [1:0] host_hi_out = 2'h0,
    output logic [1:0] clr_out = 2'h0
);
    // board enable pins, changed on an edge
    task automatic pins(input logic [1:0] a, input logic [1:0] m);
        @(posedge clk_in);
        aux_en_out <= a;
        main_en_out <= m;
    endtask
    task automatic clear(input logic [1:0] c);
        @(posedge clk_in);
        clr_out <= c;
        @(posedge clk_in);
        clr_out <= 2'h0;
    endtask
    task automatic host(input logic [1:0] a, input logic [1:0] m, input logic [1:0] h);
        @(posedge clk_in);
        aux_en_out <= 2'h0;
        main_en_out <= 2'h0;
        host_aux_out <= a;
        host_main_out <= m;
        host_hi_out <= h;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask
endmodule // board_host_model

// ===== dv/hot_plug_checker_assertions.sv
`timescale 1ns/100ps
module hot_plug_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // watched inputs
    input wire logic [1:0] aux_supply_enable_in,
    input wire logic [1:0] main_supply_enable_in,
    input wire logic [1:0] aux_high_current_select_in,
    input wire logic [1:0] aux_fault_event_in,
    input wire logic ctrl_write_in,
    input wire logic [1:0] status_clear_in,
    input wire logic int_mask_in,
    // watched outputs
    input wire logic [1:0] slot_aux_output_out,
    input wire logic [1:0] aux_limit_high_out,
    input wire logic [1:0] slot_fault_n_oe_out,
    input wire logic [1:0] aux_fault_out,
    input wire logic [1:0] main_fault_out,
    input wire logic int_n_oe_out,
    input wire logic bus_mode_out,
    input wire logic [6:0] bus_addr_out,
    input wire logic init_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // pin control settled; a write one cycle back still reaches the slots
    sequence s_run;
        init_done_out && !bus_mode_out && !ctrl_write_in && !$past(ctrl_write_in);
    endsequence
    property p_aux_on;
        s_run |=> ((slot_aux_output_out ^ $past(aux_supply_enable_in))
            & $past(~aux_fault_event_in & ~aux_fault_out)) == 2'h0;
    endproperty
    a_aux_on: assert property (p_aux_on) else $error("aux output not following enable");
    property p_aux_clr;
        s_run |=> (aux_fault_out & $past(~aux_supply_enable_in)) == 2'h0;
    endproperty
    a_aux_clr: assert property (p_aux_clr) else $error("aux fault kept with enable low");
    property p_main_clr;
        s_run |=> (main_fault_out & $past(~main_supply_enable_in)) == 2'h0;
    endproperty
    a_main_clr: assert property (p_main_clr) else $error("main fault kept with enable low");
    property p_int_set;
        $rose(|(aux_fault_out | main_fault_out)) && !int_mask_in |=> int_n_oe_out;
    endproperty
    a_int_set: assert property (p_int_set) else $error("interrupt not pulled on fault");
    property p_int_mask;
        int_mask_in |=> !int_n_oe_out;
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("masked interrupt still pulled");
    property p_int_hold;
        int_n_oe_out && !int_mask_in && status_clear_in == 2'h0 && $past(status_clear_in) == 2'h0 |=> int_n_oe_out;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt dropped without clear");
    property p_addr_hold;
        $past(init_done_out) && $past(nrst_in) |-> $stable(bus_addr_out);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved after init");
    property p_limit;
        init_done_out |=> (~aux_limit_high_out & $past(aux_high_current_select_in)) == 2'h0;
    endproperty
    a_limit: assert property (p_limit) else $error("select pin did not force high limit");
    property p_mode;
        init_done_out && ctrl_write_in || bus_mode_out |=> bus_mode_out;
    endproperty
    a_mode: assert property (p_mode) else $error("bus mode not entered or left");
    property p_fault_pin;
        slot_fault_n_oe_out == ((aux_fault_out | main_fault_out) & {2{!bus_mode_out}});
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin not matching faults");
endmodule // hot_plug_checker

bind hot_plug_slot_power_control hot_plug_checker u_chk (.clk_in, .nrst_in, .aux_supply_enable_in,
    .main_supply_enable_in, .aux_high_current_select_in, .aux_fault_event_in, .ctrl_write_in, .status_clear_in,
    .int_mask_in, .slot_aux_output_out, .aux_limit_high_out, .slot_fault_n_oe_out, .aux_fault_out,
    .main_fault_out, .int_n_oe_out, .bus_mode_out, .bus_addr_out, .init_done_out);

// ===== dv/hot_plug_slot_power_control_bench.sv
`timescale 1ns/100ps
module hot_plug_slot_power_control_bench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic int_mask_in = 1'b0;
    logic [2:0] bus_addr_select_in = 3'h5;
    logic [1:0] aux_high_current_select_in = 2'h0;
    logic [1:0] aux_fault_event_in = 2'h0;
    logic [1:0] main_fault_event_in = 2'h0;
    logic [1:0] outputs_below_off_in = 2'h0;
    logic [1:0] aux_supply_enable_in, main_supply_enable_in, host_aux_on_in, host_main_on_in, host_aux_high_in;
    logic [1:0] status_clear_in, slot_aux_output_out, slot_3v3_output_out, slot_12v_output_out, aux_limit_high_out;
    logic [1:0] slot_fault_n_out, slot_fault_n_oe_out, slot_power_off_out, aux_fault_out, main_fault_out;
    logic ctrl_write_in, int_n_out, int_n_oe_out, bus_mode_out, init_done_out;
    logic [6:0] bus_addr_out;
    int n_fail = 0;
    int total_checks = 0;
    // open-drain lines with their pull-ups
    wire int_line = !int_n_oe_out | int_n_out;
    wire [1:0] fault_line = ~slot_fault_n_oe_out | slot_fault_n_out;

    hot_plug_slot_power_control dut (.clk_in, .nrst_in, .aux_supply_enable_in, .main_supply_enable_in,
        .aux_high_current_select_in, .aux_fault_event_in, .main_fault_event_in, .outputs_below_off_in,
        .bus_addr_select_in, .ctrl_write_in, .host_aux_on_in, .host_main_on_in, .host_aux_high_in,
        .status_clear_in, .int_mask_in, .slot_aux_output_out, .slot_3v3_output_out, .slot_12v_output_out,
        .aux_limit_high_out, .slot_fault_n_out, .slot_fault_n_oe_out, .int_n_out, .int_n_oe_out,
        .slot_power_off_out, .aux_fault_out, .main_fault_out, .bus_mode_out, .bus_addr_out, .init_done_out);
    board_host_model pm (.clk_in, .aux_en_out(aux_supply_enable_in), .main_en_out(main_supply_enable_in),
        .wr_out(ctrl_write_in), .host_aux_out(host_aux_on_in), .host_main_out(host_main_on_in),
        .host_hi_out(host_aux_high_in), .clr_out(status_clear_in));

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    // compare one value
    task automatic chk(input string what, input logic [6:0] seen, input logic [6:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // let n edges land, then sample
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // address held through reset, caught once at init
    task automatic t_init();
        // reset low over the first six edges
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1;
        chk("addr rst", bus_addr_out, hot_plug_pkg::BUS_ADDR_BASE | {4'h0, hot_plug_pkg::ADDR_SEL_RESET});
        for (int i = 0; i < 40 && init_done_out !== 1'b1; i++) begin
            step(1);
        end
        // a hung init counts here and skips the scenarios
        chk("init done", init_done_out, 7'h1);
        chk("addr", bus_addr_out, hot_plug_pkg::BUS_ADDR_BASE | 7'h05);
        @(posedge clk_in);
        bus_addr_select_in <= 3'h2;
        step(2);
        chk("addr late", bus_addr_out, hot_plug_pkg::BUS_ADDR_BASE | 7'h05);
    endtask

    // pin control of both slots, each on its own
    task automatic t_direct();
        pm.pins(2'h1, 2'h1);
        aux_high_current_select_in <= 2'h1;
        step(1);
        chk("aux", slot_aux_output_out, 7'h1);
        chk("3v3", slot_3v3_output_out, 7'h1);
        chk("12v", slot_12v_output_out, 7'h1);
        chk("lim", aux_limit_high_out, 7'h1);
        pm.pins(2'h3, 2'h2);
        aux_high_current_select_in <= 2'h0;
        step(1);
        chk("3v3 b", slot_3v3_output_out, 7'h2);
        chk("lim b", aux_limit_high_out, 7'h0);
    endtask

    // fault, mask, enable drop, status clear
    task automatic t_fault();
        @(posedge clk_in);
        aux_fault_event_in <= 2'h1;
        @(posedge clk_in);
        aux_fault_event_in <= 2'h0;
        #1;
        chk("afault", aux_fault_out, 7'h1);
        chk("fpin", fault_line, 7'h2);
        step(1);
        chk("int", int_line, 7'h0);
        @(posedge clk_in);
        int_mask_in <= 1'b1;
        step(1);
        chk("int mask", int_line, 7'h1);
        @(posedge clk_in);
        int_mask_in <= 1'b0;
        pm.pins(2'h2, 2'h2);
        step(1);
        chk("afault clr", aux_fault_out, 7'h0);
        chk("int held", int_line, 7'h0);
        pm.clear(2'h3);
        step(1);
        chk("int clr", int_line, 7'h1);
        @(posedge clk_in);
        main_fault_event_in <= 2'h2;
        @(posedge clk_in);
        main_fault_event_in <= 2'h0;
        #1;
        chk("mfault", main_fault_out, 7'h2);
        pm.pins(2'h2, 2'h0);
        step(1);
        chk("mfault clr", main_fault_out, 7'h0);
        chk("off early", slot_power_off_out, 7'h0);
        pm.clear(2'h3);
        @(posedge clk_in);
        outputs_below_off_in <= 2'h2;
        step(1);
        chk("off", slot_power_off_out, 7'h2);
    endtask

    // host write takes over; select pin beats a low request
    task automatic t_bus();
        @(posedge clk_in);
        aux_high_current_select_in <= 2'h1;
        pm.host(2'h1, 2'h2, 2'h0);
        step(1);
        chk("mode", bus_mode_out, 7'h1);
        chk("aux bus", slot_aux_output_out, 7'h1);
        chk("3v3 bus", slot_3v3_output_out, 7'h2);
        chk("lim bus", aux_limit_high_out, 7'h1);
    endtask

    initial begin
        t_init();
        // scenarios need a finished init
        if (init_done_out === 1'b1) begin
            t_direct();
            t_fault();
            t_bus();
        end
        stop_test();
    end
endmodule // hot_plug_slot_power_control_bench

// ===== hw/hot_plug_pkg.sv
package hot_plug_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SLOTS = 2;
    localparam int ADDR_SEL_WIDTH = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    // address pins are caught this long after reset release
    localparam int INIT_TIME_NS = 80;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_WIDTH = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_SEL_RESET = 3'h7;
    localparam logic [6:0] BUS_ADDR_BASE = 7'h08;
    localparam int BUS_ADDR_SEL_POS = 0;

    // ------------------------------------------------------------
    // control modes
    // ------------------------------------------------------------
    typedef enum logic {
        MODE_DIRECT,
        MODE_BUS
    } ctrl_mode_t;

    typedef enum logic {
        AUX_LIMIT_LOW,
        AUX_LIMIT_HIGH
    } aux_limit_t;

    // ------------------------------------------------------------
    // per-slot carriers
    // ------------------------------------------------------------
    // pins and analog monitor events seen by one slot
    typedef struct packed {
        logic aux_supply_enable;
        logic main_supply_enable;
        logic aux_high_current_select;
        logic aux_fault_event;
        logic main_fault_event;
        logic outputs_below_off;
    } slot_in_t;

    // host side commands for one slot
    typedef struct packed {
        logic aux_on;
        logic main_on;
        logic aux_high_req;
        logic status_clear;
    } slot_cmd_t;

    // what one slot drives and reports
    typedef struct packed {
        logic slot_aux_output;
        logic slot_3v3_output;
        logic slot_12v_output;
        logic aux_limit_high;
        logic aux_fault;
        logic main_fault;
        logic fault_pending;
        logic power_off;
    } slot_out_t;

endpackage

// ===== hw/hot_plug_slot_power_control.sv
`timescale 1ns/100ps
module hot_plug_slot_power_control (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // slot pins, one bit per slot
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] aux_supply_enable_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] main_supply_enable_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] aux_high_current_select_in,
    // analog monitor events
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] aux_fault_event_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] main_fault_event_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] outputs_below_off_in,
    // address selects, open pin arrives as one
    input wire logic [hot_plug_pkg::ADDR_SEL_WIDTH-1:0] bus_addr_select_in,
    // host side commands from the bus engine
    input wire logic ctrl_write_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] host_aux_on_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] host_main_on_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] host_aux_high_in,
    input wire logic [hot_plug_pkg::NUM_SLOTS-1:0] status_clear_in,
    input wire logic int_mask_in,
    // slot outputs
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] slot_aux_output_out,
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] slot_3v3_output_out,
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] slot_12v_output_out,
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] aux_limit_high_out,
    // open-drain fault pins, enable high pulls low
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] slot_fault_n_out,
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] slot_fault_n_oe_out,
    // open-drain shared interrupt
    output logic int_n_out,
    output logic int_n_oe_out,
    // status toward the bus engine
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] slot_power_off_out,
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] aux_fault_out,
    output logic [hot_plug_pkg::NUM_SLOTS-1:0] main_fault_out,
    output logic bus_mode_out,
    output logic [6:0] bus_addr_out,
    output logic init_done_out
);

    // ------------------------------------------------------------
    // init sequence and mode
    // ------------------------------------------------------------
    // two-state sequencer: wait, then run
    typedef enum logic [1:0] {
        ST_INIT,
        ST_RUN
    } init_state_t;

    // sequencer state; leaves init once per reset
    init_state_t state_reg, state_next;
    // counter is wide enough for the init wait with room to spare
    logic [hot_plug_pkg::INIT_CNT_WIDTH-1:0] cnt_reg, cnt_next; // init wait counter
    logic [2:0] addr_reg, addr_next; // captured address selects
    // only a reset brings the block back to pin control
    hot_plug_pkg::ctrl_mode_t mode_reg, mode_next; // direct or bus control
    // registered so the shared pin never glitches between faults
    logic int_reg, int_next; // interrupt pin drive

    // ------------------------------------------------------------
    // slot results
    // ------------------------------------------------------------
    // one result bundle per slot
    hot_plug_pkg::slot_out_t slot_state [hot_plug_pkg::NUM_SLOTS];
    // per-slot interrupt causes, or-ed onto the shared pin
    logic [hot_plug_pkg::NUM_SLOTS-1:0] pending;

    // last count of the init wait, cut to counter width on purpose
    localparam logic [hot_plug_pkg::INIT_CNT_WIDTH-1:0] INIT_LAST =
        hot_plug_pkg::INIT_CNT_WIDTH'(hot_plug_pkg::INIT_CYCLES - 1);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // forms the 7-bit address from the three selects
    // selects fill the low bits, the base supplies the rest
    function automatic logic [6:0] make_addr(input logic [2:0] sel);
        make_addr = hot_plug_pkg::BUS_ADDR_BASE | {4'h0, sel};
    endfunction

    // next values for init, address, mode and interrupt
    always_comb begin
        // defaults hold state, count, address and mode
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        mode_next = mode_reg;
        case (state_reg)
            // count out the wait, then catch the selects
            ST_INIT: begin
                // host writes are ignored here: the bus engine is not up yet
                cnt_next = cnt_reg + 1'b1;
                // last wait cycle: the selects have had time to settle
                if (cnt_reg == INIT_LAST) begin
                    addr_next = bus_addr_select_in;
                    state_next = ST_RUN;
                end
            end
            // running: only the mode can still change, and only one way
            ST_RUN: begin
                // the counter freezes; it is not read again until reset
                // any control write moves to bus mode
                if (ctrl_write_in) begin
                    mode_next = hot_plug_pkg::MODE_BUS;
                end
            end
            // unused code of the state register
            default: begin
                // restart cleanly rather than hang
                state_next = ST_INIT;
            end
        endcase
        // the mask only hides the pin; the cause stays pending
        // any slot pending drives low
        int_next = (|pending) && !int_mask_in;
    end

    // registers only
    // reset is synchronous; slots get theirs through the init gate
    always_ff @(posedge clk_in) begin
        // reset: wait again, address as if all selects were open
        if (!nrst_in) begin
            state_reg <= ST_INIT;
            cnt_reg <= '0;
            addr_reg <= hot_plug_pkg::ADDR_SEL_RESET;
            mode_reg <= hot_plug_pkg::MODE_DIRECT;
            int_reg <= 1'b0;
        end else begin
            // normal run: take the next values
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            mode_reg <= mode_next;
            int_reg <= int_next;
        end
    end

    // ------------------------------------------------------------
    // slots
    // ------------------------------------------------------------
    // slots share only the clock, the gated reset, the mode and the interrupt pin
    // one independent controller per slot
    for (genvar s = 0; s < hot_plug_pkg::NUM_SLOTS; s++) begin : g_slot
        // pins and monitor events of this slot
        hot_plug_pkg::slot_in_t pins;
        // host commands of this slot
        hot_plug_pkg::slot_cmd_t cmd;
        // enables ignored in bus mode, board holds low
        assign pins = '{
            aux_supply_enable: aux_supply_enable_in[s],
            main_supply_enable: main_supply_enable_in[s],
            aux_high_current_select: aux_high_current_select_in[s],
            aux_fault_event: aux_fault_event_in[s],
            main_fault_event: main_fault_event_in[s],
            outputs_below_off: outputs_below_off_in[s]};
        // bus-mode enables, used only after a control write; high request and status clear act in either mode
        assign cmd = '{
            aux_on: host_aux_on_in[s],
            main_on: host_main_on_in[s],
            aux_high_req: host_aux_high_in[s],
            status_clear: status_clear_in[s]};
        // slot held in reset until init ends, so nothing turns on early
        slot_power_ctrl u_slot (
            .clk_in(clk_in),
            .nrst_in(nrst_in && (state_reg == ST_RUN)),
            .pins_in(pins),
            .cmd_in(cmd),
            .mode_in(mode_reg),
            .state_out(slot_state[s])
        );
        // unpack the registered results onto the slot's pins
        assign slot_aux_output_out[s] = slot_state[s].slot_aux_output;
        assign slot_3v3_output_out[s] = slot_state[s].slot_3v3_output;
        assign slot_12v_output_out[s] = slot_state[s].slot_12v_output;
        assign aux_limit_high_out[s] = slot_state[s].aux_limit_high;
        // fault and power-off status for the bus engine
        assign aux_fault_out[s] = slot_state[s].aux_fault;
        assign main_fault_out[s] = slot_state[s].main_fault;
        assign slot_power_off_out[s] = slot_state[s].power_off;
        // interrupt cause of this slot
        assign pending[s] = slot_state[s].fault_pending;
        // pin low only in direct mode
        assign slot_fault_n_oe_out[s] = (slot_state[s].aux_fault | slot_state[s].main_fault)
            && (mode_reg == hot_plug_pkg::MODE_DIRECT);
        // level fixed low, only the enable moves
        assign slot_fault_n_out[s] = 1'b0;
    end

    // ------------------------------------------------------------
    // shared outputs
    // ------------------------------------------------------------
    // open drain: level always low, enable pulls
    assign int_n_out = 1'b0;
    assign int_n_oe_out = int_reg;
    // mode straight from its register
    assign bus_mode_out = (mode_reg == hot_plug_pkg::MODE_BUS);
    // address reads as all open until init has caught the selects
    assign bus_addr_out = make_addr(addr_reg);
    // requests are safe from this point on
    assign init_done_out = (state_reg == ST_RUN);

endmodule // hot_plug_slot_power_control

// ===== hw/slot_power_ctrl.sv
`timescale 1ns/100ps
module slot_power_ctrl (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // pins and monitors
    input wire hot_plug_pkg::slot_in_t pins_in,
    // host commands
    input wire hot_plug_pkg::slot_cmd_t cmd_in,
    input wire hot_plug_pkg::ctrl_mode_t mode_in,
    // results
    output hot_plug_pkg::slot_out_t state_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic aux_fault_reg, aux_fault_next; // latched aux fault
    logic main_fault_reg, main_fault_next; // latched main fault
    logic pend_reg, pend_next; // interrupt cause, kept until cleared
    hot_plug_pkg::slot_out_t out_reg, out_next;
    logic aux_en, main_en;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        // source of enables depends on mode
        if (mode_in == hot_plug_pkg::MODE_DIRECT) begin
            aux_en = pins_in.aux_supply_enable;
            main_en = pins_in.main_supply_enable;
        end else begin
            aux_en = cmd_in.aux_on;
            main_en = cmd_in.main_on;
        end
        if (!aux_en) begin
            aux_fault_next = 1'b0;
        end else begin
            aux_fault_next = aux_fault_reg | pins_in.aux_fault_event;
        end
        if (!main_en) begin
            main_fault_next = 1'b0;
        end else begin
            main_fault_next = main_fault_reg | pins_in.main_fault_event;
        end
        // new fault sets; set wins over host clear
        if ((aux_en && pins_in.aux_fault_event) || (main_en && pins_in.main_fault_event)) begin
            pend_next = 1'b1;
        end else if (cmd_in.status_clear) begin
            pend_next = 1'b0;
        end else begin
            pend_next = pend_reg;
        end
        out_next = '0;
        // aux follows level, fault shuts it
        out_next.slot_aux_output = aux_en && !aux_fault_next;
        out_next.slot_3v3_output = main_en && !main_fault_next;
        out_next.slot_12v_output = main_en && !main_fault_next;
        out_next.aux_limit_high = pins_in.aux_high_current_select | cmd_in.aux_high_req;
        out_next.aux_fault = aux_fault_next;
        out_next.main_fault = main_fault_next;
        out_next.fault_pending = pend_next;
        // off once main off and rails bled
        out_next.power_off = !main_en && pins_in.outputs_below_off;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            aux_fault_reg <= 1'b0;
            main_fault_reg <= 1'b0;
            pend_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            aux_fault_reg <= aux_fault_next;
            main_fault_reg <= main_fault_next;
            pend_reg <= pend_next;
            out_reg <= out_next;
        end
    end

    assign state_out = out_reg;

endmodule // slot_power_ctrl
